//--- gct_timer3.v
// What this block does
// - Mode field bits 5:3: 000 timer, 001 counter, 010 gate low, 011 gate high.
// - Mode 110 incremental rotation, 111 incremental edge; 100 and 101 unused.
// - Run bit 6 stops the core timer when 0, lets it count when 1.
// - Without external direction, bit 7 counts up at 0, down at 1.
// - External direction enable bit 8 takes direction from the up/down line.
// - Output enable bit 9 puts the toggle latch on the timer output pin.
// - Toggle latch bit 10 inverts on each wrap except one in the cycle of a control write, which loads it instead.
// - Fast mode bit 11 samples inputs every 8 clocks at 0, every 4 at 1.
// - Edge flag bit 12 is set on each counted edge, cleared by software.
// - Direction change flag bit 13 is set on reversal, cleared by software.
// - Bit 14 is read-only and shows the current direction, 1 for down.
// - Interrupt enable bit 15 gates requests from the edge and direction flags.
// - Timer and gated modes prescale by 8 to 1024, or 4 to 512 fast.
// - Every register of the unit resets to zero.
// - Counter mode: 000 off, 001 rising, 010 falling, 011 both edges.
// - Incremental: 000 stop, 001 count line, 010 up/down line, 011 both.
//
// Design decision made here: register access over AHB-Lite.
`timescale 1ns/10ps
`include "gct_defines.vh"

module gct_timer3 (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output wire [31:0] hrdata,
  input wire count_input_line,
  input wire up_down_input_line,
  output wire timer_output_pin,
  output wire flag_interrupt_req
);

  // Maps a byte address onto a local register select.
  function [3:0] gct_decode;
    input [31:0] a;
    begin
      if (a[31:18] != 14'h0000 || a[1:0] != 2'h0) begin
        gct_decode = `GCT_SEL_NONE;
      end else begin
        case (a[17:2])
          `GCT_IDX_T2CNT: gct_decode = `GCT_SEL_T2CNT;
          `GCT_IDX_T3CNT: gct_decode = `GCT_SEL_T3CNT;
          `GCT_IDX_T4CNT: gct_decode = `GCT_SEL_T4CNT;
          `GCT_IDX_T5CNT: gct_decode = `GCT_SEL_T5CNT;
          `GCT_IDX_T6CNT: gct_decode = `GCT_SEL_T6CNT;
          `GCT_IDX_CAPTURE_RELOAD_VALUE: gct_decode = `GCT_SEL_CAPTURE_RELOAD_VALUE;
          `GCT_IDX_CLC: gct_decode = `GCT_SEL_CLC;
          `GCT_IDX_TIMER_TWO_CONTROL: gct_decode = `GCT_SEL_TIMER_TWO_CONTROL;
          `GCT_IDX_CORE_TIMER_CONTROL: gct_decode = `GCT_SEL_CORE_TIMER_CONTROL;
          `GCT_IDX_TIMER_FOUR_CONTROL: gct_decode = `GCT_SEL_TIMER_FOUR_CONTROL;
          `GCT_IDX_TIMER_FIVE_CONTROL: gct_decode = `GCT_SEL_TIMER_FIVE_CONTROL;
          `GCT_IDX_TIMER_SIX_CONTROL: gct_decode = `GCT_SEL_TIMER_SIX_CONTROL;
          default: gct_decode = `GCT_SEL_NONE;
        endcase
      end
    end
  endfunction

  // Sense of one lone quadrature step, 1 for down. A lone edge on phase A moves up
  // when the phases now differ; a lone edge on phase B moves up when they now agree.
  function gct_quad_down;
    input moved;
    input other;
    input moved_is_b;
    begin
      gct_quad_down = (moved == other) ^ moved_is_b;
    end
  endfunction

  // Bus slave states, one-hot.
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_RWAIT = 2'b10;

  reg [1:0] state_r;
  reg [3:0] sel_r;
  reg wr_pend_r;
  reg hreadyout_r;
  reg hresp_r;
  reg [31:0] hrdata_r;
  reg [15:0] plain_r [0:`GCT_NUM_REGS-1];

  // Core timer state.
  reg [15:0] count_r;
  reg [2:0] isel_r;
  reg [2:0] mode_r;
  reg run_r;
  reg udbit_r;
  reg ude_r;
  reg oe_r;
  reg otl_r;
  reg fm_r;
  reg edge_r;
  reg chdir_r;
  reg dir_r;
  reg iren_r;
  reg [`GCT_PRE_W-1:0] pre_r;
  reg pin_r;
  reg irq_r;

  wire addr_ok = hsel & hready & (htrans == `GCT_HTRANS_NONSEQ);
  wire [3:0] sel_now = gct_decode(haddr);
  wire wr_cnt = wr_pend_r & (sel_r == `GCT_SEL_T3CNT);
  wire wr_con = wr_pend_r & (sel_r == `GCT_SEL_CORE_TIMER_CONTROL);
  wire [15:0] wdat = hwdata[15:0];

  wire [15:0] con_word = {iren_r, dir_r, chdir_r, edge_r, fm_r, otl_r, oe_r, ude_r,
                          udbit_r, run_r, mode_r, isel_r};

  // Bus slave: writes finish without wait, reads take one wait state.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= ST_IDLE;
      sel_r <= `GCT_SEL_NONE;
      wr_pend_r <= 1'b0;
      hreadyout_r <= 1'b1;
      hresp_r <= 1'b0;
      hrdata_r <= 32'h00000000;
    end else begin
      case (state_r)
        ST_IDLE: begin
          wr_pend_r <= addr_ok & hwrite;
          sel_r <= addr_ok ? sel_now : `GCT_SEL_NONE;
          if (addr_ok && !hwrite) begin
            state_r <= ST_RWAIT;
            hreadyout_r <= 1'b0;
          end
        end
        ST_RWAIT: begin
          wr_pend_r <= 1'b0;
          state_r <= ST_IDLE;
          hreadyout_r <= 1'b1;
          case (sel_r)
            `GCT_SEL_T3CNT: hrdata_r <= {16'h0000, count_r};
            `GCT_SEL_CORE_TIMER_CONTROL: hrdata_r <= {16'h0000, con_word};
            `GCT_SEL_NONE: hrdata_r <= 32'h00000000;
            default: hrdata_r <= {16'h0000, plain_r[sel_r]};
          endcase
        end
        default: begin
          state_r <= ST_IDLE;
          hreadyout_r <= 1'b1;
          wr_pend_r <= 1'b0;
        end
      endcase
    end
  end

  // Storage for the unit's other registers.
  genvar g;
  generate
    for (g = 0; g < `GCT_NUM_REGS; g = g + 1) begin : plain_regs
      if (g != `GCT_SEL_T3CNT && g != `GCT_SEL_CORE_TIMER_CONTROL) begin : keep
        always @(posedge hclk or negedge hresetn) begin
          if (!hresetn) begin
            plain_r[g] <= `GCT_RST16;
          end else if (wr_pend_r && sel_r == g) begin
            plain_r[g] <= wdat;
          end
        end
      end
    end
  endgenerate

  // Prescaler and input sample strobe.
  wire [3:0] pre_shift = {1'b0, isel_r} + `GCT_PRE_BASE - {3'h0, fm_r};
  wire [10:0] pre_mask_w = (11'h001 << pre_shift) - 11'h001;
  wire [`GCT_PRE_W-1:0] pre_mask = pre_mask_w[`GCT_PRE_W-1:0];
  wire tick = (pre_r & pre_mask) == pre_mask;
  wire sample = fm_r ? (pre_r[1:0] == `GCT_SMP_FAST) : (pre_r[2:0] == `GCT_SMP_SLOW);

  wire a_lvl;
  wire a_rise;
  wire a_fall;
  wire b_lvl;
  wire b_rise;
  wire b_fall;

  gct_edge_unit u_count_edge (
    .hclk(hclk),
    .hresetn(hresetn),
    .sample(sample),
    .line_in(count_input_line),
    .level_o(a_lvl),
    .rise_o(a_rise),
    .fall_o(a_fall)
  );

  gct_edge_unit u_dir_edge (
    .hclk(hclk),
    .hresetn(hresetn),
    .sample(sample),
    .line_in(up_down_input_line),
    .level_o(b_lvl),
    .rise_o(b_rise),
    .fall_o(b_fall)
  );

  wire a_any = a_rise | a_fall;
  wire b_any = b_rise | b_fall;

  // Counting decision.
  reg step;
  reg edge_ev;
  reg dir_nxt;
  always @* begin
    step = 1'b0;
    edge_ev = 1'b0;
    dir_nxt = ude_r ? up_down_input_line : udbit_r;
    case (mode_r)
      `GCT_M_TIMER: begin
        step = tick;
      end
      `GCT_M_COUNTER: begin
        case (isel_r)
          `GCT_I_SEL1: edge_ev = a_rise;
          `GCT_I_SEL2: edge_ev = a_fall;
          `GCT_I_SEL3: edge_ev = a_any;
          default: edge_ev = 1'b0;
        endcase
        step = edge_ev;
      end
      `GCT_M_GATE_LO: begin
        step = tick & ~a_lvl;
      end
      `GCT_M_GATE_HI: begin
        step = tick & a_lvl;
      end
      `GCT_M_INC_ROT, `GCT_M_INC_EDGE: begin
        dir_nxt = dir_r;
        case (isel_r)
          `GCT_I_SEL1: edge_ev = a_any;
          `GCT_I_SEL2: edge_ev = b_any;
          `GCT_I_SEL3: edge_ev = a_any | b_any;
          default: edge_ev = 1'b0;
        endcase
        // Quadrature phase gives the sense; the direction bit inverts it.
        // A stopped counter keeps its sense, so no direction change is flagged.
        if (!run_r) begin
          dir_nxt = dir_r;
        end else if (edge_ev && a_any && !b_any) begin
          dir_nxt = gct_quad_down(count_input_line, b_lvl, 1'b0) ^ udbit_r;
        end else if (edge_ev && b_any && !a_any) begin
          dir_nxt = gct_quad_down(up_down_input_line, a_lvl, 1'b1) ^ udbit_r;
        end
        step = edge_ev;
      end
      default: begin
        step = 1'b0;
      end
    endcase
    step = step & run_r;
    edge_ev = edge_ev & run_r;
  end

  wire wrap = step & (dir_nxt ? (count_r == `GCT_RST16) : (count_r == `GCT_CNT_MAX));
  wire chdir_ev = (dir_nxt != dir_r);
  wire edge_set = edge_ev;
  wire chdir_set = chdir_ev;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre_r <= {`GCT_PRE_W{1'b0}};
      count_r <= `GCT_RST16;
      isel_r <= 3'h0;
      mode_r <= 3'h0;
      run_r <= 1'b0;
      udbit_r <= 1'b0;
      ude_r <= 1'b0;
      oe_r <= 1'b0;
      fm_r <= 1'b0;
      dir_r <= 1'b0;
      iren_r <= 1'b0;
    end else begin
      pre_r <= pre_r + {{(`GCT_PRE_W-1){1'b0}}, 1'b1};
      dir_r <= dir_nxt;
      if (wr_cnt) begin
        count_r <= wdat;
      end else if (step) begin
        count_r <= dir_nxt ? count_r - 16'h0001 : count_r + 16'h0001;
      end
      if (wr_con) begin
        isel_r <= wdat[`GCT_F_ISEL];
        mode_r <= wdat[`GCT_F_MODE];
        run_r <= wdat[`GCT_B_RUN];
        udbit_r <= wdat[`GCT_B_UD];
        ude_r <= wdat[`GCT_B_UDE];
        oe_r <= wdat[`GCT_B_OE];
        fm_r <= wdat[`GCT_B_FM];
        iren_r <= wdat[`GCT_B_IREN];
      end
    end
  end

  // Toggle latch and sticky flags. A software write loads the latch outright, while a
  // flag that hardware sets in the same cycle survives the write, so no event is lost.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      otl_r <= 1'b0;
      edge_r <= 1'b0;
      chdir_r <= 1'b0;
    end else if (wr_con) begin
      otl_r <= wdat[`GCT_B_OTL];
      edge_r <= wdat[`GCT_B_EDGE] | edge_set;
      chdir_r <= wdat[`GCT_B_CHDIR] | chdir_set;
    end else begin
      if (wrap) begin
        otl_r <= ~otl_r;
      end
      if (edge_set) begin
        edge_r <= 1'b1;
      end
      if (chdir_set) begin
        chdir_r <= 1'b1;
      end
    end
  end

  // Pin and request are registered so that both leave the block straight from a flop.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      pin_r <= oe_r & otl_r;
      irq_r <= iren_r & (edge_set | chdir_set);
    end
  end

  assign hreadyout = hreadyout_r;
  assign hresp = hresp_r;
  assign hrdata = hrdata_r;
  assign timer_output_pin = pin_r;
  assign flag_interrupt_req = irq_r;

endmodule

//--- gct_defines.vh
`ifndef GCT_DEFINES_VH
`define GCT_DEFINES_VH

// Register indices; the byte address on the bus is four times the index.
`define GCT_IDX_T2CNT 16'hfe40
`define GCT_IDX_T3CNT 16'hfe42
`define GCT_IDX_T4CNT 16'hfe44
`define GCT_IDX_T5CNT 16'hfe46
`define GCT_IDX_T6CNT 16'hfe48
`define GCT_IDX_CAPTURE_RELOAD_VALUE 16'hfe4a
`define GCT_IDX_CLC 16'hfe4c
`define GCT_IDX_TIMER_TWO_CONTROL 16'hff40
`define GCT_IDX_CORE_TIMER_CONTROL 16'hff42
`define GCT_IDX_TIMER_FOUR_CONTROL 16'hff44
`define GCT_IDX_TIMER_FIVE_CONTROL 16'hff46
`define GCT_IDX_TIMER_SIX_CONTROL 16'hff48

// Local register selects.
`define GCT_SEL_T2CNT 4'h0
`define GCT_SEL_T3CNT 4'h1
`define GCT_SEL_T4CNT 4'h2
`define GCT_SEL_T5CNT 4'h3
`define GCT_SEL_T6CNT 4'h4
`define GCT_SEL_CAPTURE_RELOAD_VALUE 4'h5
`define GCT_SEL_CLC 4'h6
`define GCT_SEL_TIMER_TWO_CONTROL 4'h7
`define GCT_SEL_CORE_TIMER_CONTROL 4'h8
`define GCT_SEL_TIMER_FOUR_CONTROL 4'h9
`define GCT_SEL_TIMER_FIVE_CONTROL 4'ha
`define GCT_SEL_TIMER_SIX_CONTROL 4'hb
`define GCT_SEL_NONE 4'hf
`define GCT_NUM_REGS 12

// Control register field positions.
`define GCT_F_ISEL 2:0
`define GCT_F_MODE 5:3
`define GCT_B_RUN 6
`define GCT_B_UD 7
`define GCT_B_UDE 8
`define GCT_B_OE 9
`define GCT_B_OTL 10
`define GCT_B_FM 11
`define GCT_B_EDGE 12
`define GCT_B_CHDIR 13
`define GCT_B_RDIR 14
`define GCT_B_IREN 15

// Mode codes.
`define GCT_M_TIMER 3'h0
`define GCT_M_COUNTER 3'h1
`define GCT_M_GATE_LO 3'h2
`define GCT_M_GATE_HI 3'h3
`define GCT_M_INC_ROT 3'h6
`define GCT_M_INC_EDGE 3'h7

// Input selection codes.
`define GCT_I_OFF 3'h0
`define GCT_I_SEL1 3'h1
`define GCT_I_SEL2 3'h2
`define GCT_I_SEL3 3'h3

// Prescaler: least shift is 3 (factor 8), fast mode takes one off.
`define GCT_PRE_BASE 4'h3
`define GCT_PRE_W 10
`define GCT_SMP_SLOW 3'h7
`define GCT_SMP_FAST 2'h3

`define GCT_RST16 16'h0000
`define GCT_CNT_MAX 16'hffff
`define GCT_HTRANS_NONSEQ 2'h2

`endif

//--- gct_edge_unit.v
`timescale 1ns/10ps
`include "gct_defines.vh"

module gct_edge_unit (
  input wire hclk,
  input wire hresetn,
  input wire sample,
  input wire line_in,
  output wire level_o,
  output wire rise_o,
  output wire fall_o
);
  reg level_r;

  // The line is looked at only on sample strobes, which limits the input rate.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      level_r <= 1'b0;
    end else if (sample) begin
      level_r <= line_in;
    end
  end

  assign level_o = level_r;
  assign rise_o = sample & line_in & ~level_r;
  assign fall_o = sample & ~line_in & level_r;
endmodule

//--- gct_line_model.sv
`timescale 1ns/10ps
module gct_line_model (
  input wire hclk,
  output logic count_input_line,
  output logic up_down_input_line
);
  initial begin
    count_input_line = 1'b0;
    up_down_input_line = 1'b0;
  end
  // Each level is held for two slow sample periods, so no strobe misses it.
  task automatic drive(input logic a, input logic b);
    @(posedge hclk);
    count_input_line <= a;
    up_down_input_line <= b;
    repeat (16) @(posedge hclk);
  endtask
endmodule

//--- gct_timer3_checker.sv
`timescale 1ns/10ps
`include "gct_defines.vh"
module gct_timer3_checker (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hwdata,
  input wire hready,
  input wire hreadyout,
  input wire hresp,
  input wire [31:0] hrdata,
  input wire timer_output_pin,
  input wire flag_interrupt_req
);
  wire take = hsel && hready && htrans == `GCT_HTRANS_NONSEQ;
  reg wr_ctl_r;
  reg [15:0] ctl_r;
  // Shadow of the last control word written, used to judge output gating.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ctl_r <= 1'b0;
      ctl_r <= 16'h0000;
    end else begin
      wr_ctl_r <= take && hwrite && haddr == {14'h0000, `GCT_IDX_CORE_TIMER_CONTROL, 2'h0};
      if (wr_ctl_r) ctl_r <= hwdata[15:0];
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_resp_okay: assert property (hresp == 1'b0) else $error("response not okay");
  a_read_one_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait not one cycle");
  a_write_no_wait: assert property (take && hwrite |=> hreadyout)
    else $error("write stalled");
  a_rdata_holds: assert property (!$stable(hrdata) |-> $past(hreadyout) == 1'b0)
    else $error("read data moved outside a read");
  a_unmapped_zero: assert property (take && !hwrite && haddr[31:18] != 14'h0000
    |-> ##2 hrdata == 32'h00000000) else $error("unmapped read not zero");
  a_pin_needs_oe: assert property (timer_output_pin |-> $past(ctl_r[9]))
    else $error("output pin high while disabled");
  a_latch_write: assert property (wr_ctl_r |-> ##2 timer_output_pin ==
    ($past(hwdata[9], 2) && $past(hwdata[10], 2))) else $error("latch write not on pin");
  a_irq_needs_en: assert property (flag_interrupt_req |-> ctl_r[15] || $past(ctl_r[15]))
    else $error("interrupt while disabled");
endmodule
bind gct_timer3 gct_timer3_checker i_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .timer_output_pin(timer_output_pin),
  .flag_interrupt_req(flag_interrupt_req));

//--- gct_timer3_tb.sv
`timescale 1ns/10ps
`include "gct_defines.vh"
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin miscompares++; \
  $display("Error at %0t: got %h want %h", $time, (a), (e)); end end
module gct_timer3_tb;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h00000000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h00000000;
  logic [31:0] rd;
  wire hreadyout;
  wire hresp;
  wire [31:0] hrdata;
  wire cnt_line;
  wire ud_line;
  wire out_pin;
  wire irq;
  int checks = 0;
  int miscompares = 0;
  int irqs = 0;
  logic [15:0] qc [11] = '{16'h004a, 16'h004b, 16'h0048, 16'h014a, 16'h0071, 16'h0072,
    16'h0073, 16'h007b, 16'h0070, 16'h0031, 16'h000b};
  logic [15:0] qe [11] = '{16'h0001, 16'h0002, 16'h0000, 16'hffff, 16'h0002, 16'h0002,
    16'h0004, 16'h0004, 16'h0000, 16'h0000, 16'h0000};
  gct_timer3 i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .count_input_line(cnt_line),
    .up_down_input_line(ud_line), .timer_output_pin(out_pin), .flag_interrupt_req(irq));
  gct_line_model i_line (.hclk(hclk), .count_input_line(cnt_line),
    .up_down_input_line(ud_line));
  initial forever #4 hclk = ~hclk;
  always @(posedge hclk) if (irq === 1'b1) irqs++;
  function automatic [31:0] adr(input [15:0] idx);
    adr = {14'h0000, idx, 2'h0};
  endfunction
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= `GCT_HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  // One full forward quadrature cycle on the two lines, then the count is read.
  task automatic quad(input logic [15:0] ctl, input logic [15:0] exp);
    ahb(1'b1, adr(`GCT_IDX_T3CNT), 32'h00000000);
    ahb(1'b1, adr(`GCT_IDX_CORE_TIMER_CONTROL), {16'h0000, ctl});
    i_line.drive(1'b1, 1'b0);
    i_line.drive(1'b1, 1'b1);
    i_line.drive(1'b0, 1'b1);
    i_line.drive(1'b0, 1'b0);
    ahb(1'b0, adr(`GCT_IDX_T3CNT), 32'h00000000);
    `CHK(rd[15:0], exp)
  endtask
  task automatic tmr(input logic [15:0] ctl, input int f, input int lo, input int hi);
    ahb(1'b1, adr(`GCT_IDX_T3CNT), 32'h00000000);
    ahb(1'b1, adr(`GCT_IDX_CORE_TIMER_CONTROL), {16'h0000, ctl});
    repeat (8 * f) @(posedge hclk);
    ahb(1'b1, adr(`GCT_IDX_CORE_TIMER_CONTROL), 32'h00000000);
    ahb(1'b0, adr(`GCT_IDX_T3CNT), 32'h00000000);
    `CHK(rd[15:0] >= 16'(lo) && rd[15:0] <= 16'(hi), 1'b1)
  endtask
  task automatic conclude;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #640000;
    miscompares++;
    conclude;
  end
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 12; i++) begin
      ahb(1'b0, adr(i < 7 ? 16'(16'hfe40 + 2 * i) : 16'(16'hff40 + 2 * (i - 7))), 32'h0);
      `CHK(rd, 32'h00000000)
    end
    $display("test reset_values done");
    ahb(1'b1, 32'h00040000, 32'h0000ffff);
    ahb(1'b0, 32'h00040000, 32'h00000000);
    `CHK(rd, 32'h00000000)
    ahb(1'b1, adr(`GCT_IDX_T5CNT), 32'h0000a5c3);
    ahb(1'b0, adr(`GCT_IDX_T5CNT), 32'h00000000);
    `CHK(rd, 32'h0000a5c3)
    $display("test bus_access done");
    quad(16'h8049, 16'h0001);
    ahb(1'b0, adr(`GCT_IDX_CORE_TIMER_CONTROL), 32'h00000000);
    `CHK(rd[15:0], 16'h9049)
    `CHK(irqs, 1)
    for (int i = 0; i < 11; i++) quad(qc[i], qe[i]);
    $display("test edge_modes done");
    quad(16'h02c9, 16'hffff);
    ahb(1'b0, adr(`GCT_IDX_CORE_TIMER_CONTROL), 32'h00000000);
    `CHK(rd[15:0], 16'h76c9)
    `CHK(out_pin, 1'b1)
    ahb(1'b1, adr(`GCT_IDX_CORE_TIMER_CONTROL), 32'h00004200);
    ahb(1'b0, adr(`GCT_IDX_CORE_TIMER_CONTROL), 32'h00000000);
    `CHK(rd[15:0], 16'h2200)
    `CHK(out_pin, 1'b0)
    ahb(1'b1, adr(`GCT_IDX_CORE_TIMER_CONTROL), 32'h00000600);
    ahb(1'b0, adr(`GCT_IDX_CORE_TIMER_CONTROL), 32'h00000000);
    `CHK(rd[15:0], 16'h0600)
    `CHK(out_pin, 1'b1)
    $display("test toggle_latch done");
    for (int f = 0; f < 2; f++)
      for (int i = 0; i < 8; i++) tmr(16'(f * 16'h0800 + 16'h0040 + i), (f ? 4 : 8) << i, 8, 9);
    tmr(16'h0050, 8, 8, 9);
    tmr(16'h0058, 8, 0, 0);
    $display("test prescale done");
    conclude;
  end
endmodule
